// File: src/prox_track_map.svh
/*
 Register indices, field positions, reset values and timing figures
 of the proximity and ambient tracker. Assumes a 32-bit APB bus whose
 byte address is four times the register index.
*/
`ifndef PROX_TRACK_MAP_SVH
`define PROX_TRACK_MAP_SVH

`define IDX_SKIP 10'h002
`define IDX_LVL 10'h003
`define IDX_SEQ 10'h010
`define IDX_STAT 10'h011
`define IDX_CLR 10'h012
`define IDX_IEN 10'h013
`define IDX_PROX 10'h014
`define IDX_OFFS 10'h020
`define IDX_TRIP 10'h028
`define IDX_AMB 10'h030

`define SKIP_LSB 0
`define HOVER_LSB 0
`define APPR_LSB 8
`define SLOW_LSB 14
`define LAST_LSB 0
`define POS_LSB 4
`define NEG_LSB 8

`define SKIP_RST 4'h0
`define LVL_RST 16'h0000
`define SEQ_RST 12'h007

`define LVL_SHIFT 4
`define FAST_DEPTH 4
`define FAST_UPD_D64_MS 0.768

`endif

// File: src/prox_track_pkg.sv
/*
 Types shared by the tracker. Assumes the constants header alongside.
*/
package prox_track_pkg;
    typedef struct packed {
        logic [2:0] stage;
        logic [15:0] data;
    } conv_t;

    typedef struct packed {
        logic [1:0] slow;
        logic [5:0] approach;
        logic [7:0] hover;
    } level_cfg_t;

    typedef struct packed {
        logic approach;
        logic hover;
        logic slow_ok;
    } prox_res_t;

    typedef enum logic [1:0] {
        DEC_64 = 2'b00,
        DEC_128 = 2'b01,
        DEC_256 = 2'b10
    } decim_t;
endpackage

// File: src/prox_compare.sv
/*
 Three comparators of one stage: approach, hover and slow update.
 Assumes the caller gives the words of the stage being converted.
*/
`timescale 1ns/1ns
`default_nettype none
module prox_compare
    import prox_track_pkg::*;
(
    input wire logic [15:0] sample_i,
    input wire logic [15:0] older_i,
    input wire logic [15:0] avg_i,
    input wire logic [15:0] ambient_i,
    input wire logic [15:0] slow_word_i,
    input wire level_cfg_t lvl_i,
    output var prox_res_t res_o
);
    function automatic logic [15:0] absdiff(input logic [15:0] a,
                                            input logic [15:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction

    logic [15:0] appr_thr;
    logic [15:0] hov_thr;
    assign appr_thr = {6'h00, lvl_i.approach, 4'h0};
    assign hov_thr = {4'h0, lvl_i.hover, 4'h0};
    assign res_o.approach = absdiff(sample_i, older_i) > appr_thr;
    // Also catches an ambient left shifted by moisture or dirt
    assign res_o.hover = absdiff(avg_i, ambient_i) > hov_thr;
    assign res_o.slow_ok = absdiff(sample_i, slow_word_i)
                           > {14'h0000, lvl_i.slow};
endmodule
`default_nettype wire

// File: src/touch_proximity_ambient_tracker.sv
/*
 Proximity detection and ambient tracking for a multi-stage touch
 converter, with an APB register slave and one level interrupt.
 Assumes conversion results arrive on core_clk_i from the sequencer
 and the APB master runs on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "prox_track_map.svh"
module touch_proximity_ambient_tracker
    import prox_track_pkg::*;
#(
    parameter int NUM_STAGES = 8
)
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic conv_valid_i,
    input wire conv_t conv_i,
    output logic irq_o
);
    function automatic logic in_bank(input logic [9:0] idx,
                                     input logic [9:0] base);
        in_bank = (idx >= base) && (idx < base + 10'(NUM_STAGES));
    endfunction

    function automatic logic [15:0] trip(input logic [15:0] amb,
                                         input logic [15:0] off,
                                         input logic [3:0] sens,
                                         input logic up);
        logic [19:0] q;
        logic [19:0] s;
        logic [15:0] t;
        q = {4'h0, off} >> 2;
        s = (({4'h0, off} - q) >> 4) * {16'h0000, sens};
        t = q[15:0] + s[15:0];
        trip = up ? amb + t : amb - t;
    endfunction

    // Configuration
    logic [3:0] skip_r;
    level_cfg_t lvl_r;
    logic [2:0] last_stage_r;
    logic [3:0] pos_sens_r;
    logic [3:0] neg_sens_r;
    logic [NUM_STAGES-1:0] stat_r;
    logic [NUM_STAGES-1:0] ien_r;

    // Per-stage memory
    logic [15:0] ff_mem [NUM_STAGES][`FAST_DEPTH];
    logic [15:0] sf_mem [NUM_STAGES];
    logic [15:0] amb_mem [NUM_STAGES];
    logic [15:0] uoff_mem [NUM_STAGES];
    logic [15:0] loff_mem [NUM_STAGES];
    logic [15:0] utrip_mem [NUM_STAGES];
    logic [15:0] ltrip_mem [NUM_STAGES];
    logic [NUM_STAGES-1:0] appr_r;
    logic [NUM_STAGES-1:0] hover_r;

    logic [3:0] seq_cnt_r;
    logic pass;
    logic acc;
    logic [2:0] st;
    logic [15:0] d;
    logic [17:0] sum;
    logic [15:0] avg;
    logic stage_prox;
    logic slow_upd;
    logic contact;
    prox_res_t res;

    assign acc = clk_en_i && conv_valid_i;
    assign st = conv_i.stage;
    assign d = conv_i.data;
    assign pass = (seq_cnt_r == 4'h0);
    assign sum = {2'b00, d} + {2'b00, ff_mem[st][0]}
                 + {2'b00, ff_mem[st][1]} + {2'b00, ff_mem[st][2]};
    assign avg = sum[17:2];

    prox_compare u_cmp (
        .sample_i(d),
        .older_i(ff_mem[st][1]),
        .avg_i(avg),
        .ambient_i(amb_mem[st]),
        .slow_word_i(sf_mem[st]),
        .lvl_i(lvl_r),
        .res_o(res)
    );

    // Flags in force for this conversion; fresh ones on a fast update
    assign stage_prox = (acc && pass) ? (res.approach || res.hover)
                        : (appr_r[st] || hover_r[st]);
    assign contact = (d > utrip_mem[st]) || (d < ltrip_mem[st]);
    assign slow_upd = acc && res.slow_ok && !stage_prox
                      && !contact;

    // APB decode
    logic [9:0] idx;
    logic wr_go;
    logic rd_ok;
    logic [31:0] rd_nxt;
    logic [2:0] sub;
    assign idx = paddr_i[11:2];
    assign sub = idx[2:0];
    assign wr_go = clk_en_i && psel_i && penable_i && pready_o && pwrite_i;

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        rd_ok = 1'b1;
        if (idx == `IDX_SKIP)
            rd_nxt[3:0] = skip_r;
        else if (idx == `IDX_LVL)
            rd_nxt[15:0] = lvl_r;
        else if (idx == `IDX_SEQ)
            rd_nxt[11:0] = {neg_sens_r, pos_sens_r, 1'b0, last_stage_r};
        else if (idx == `IDX_STAT)
            rd_nxt[NUM_STAGES-1:0] = stat_r;
        else if (idx == `IDX_CLR)
            rd_nxt = 32'h0000_0000;
        else if (idx == `IDX_IEN)
            rd_nxt[NUM_STAGES-1:0] = ien_r;
        else if (idx == `IDX_PROX)
            rd_nxt[15:0] = {hover_r, appr_r};
        else if (in_bank(idx, `IDX_OFFS))
            rd_nxt = {loff_mem[sub], uoff_mem[sub]};
        else if (in_bank(idx, `IDX_TRIP))
            rd_nxt = {ltrip_mem[sub], utrip_mem[sub]};
        else if (in_bank(idx, `IDX_AMB))
            rd_nxt[15:0] = amb_mem[sub];
        else
            rd_ok = 1'b0;
    end

    // One wait state, then the answer stands for the completing edge
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pready_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (psel_i && penable_i && !pready_o)
            begin
                pready_o <= 1'b1;
                prdata_o <= pwrite_i ? 32'h0000_0000 : rd_nxt;
                pslverr_o <= !rd_ok;
            end
            else
            begin
                pready_o <= 1'b0;
                pslverr_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            skip_r <= `SKIP_RST;
            lvl_r <= `LVL_RST;
            {neg_sens_r, pos_sens_r, last_stage_r} <= 11'h007;
        end
        else if (wr_go)
        begin
            if (idx == `IDX_SKIP)
                skip_r <= pwdata_i[`SKIP_LSB +: 4];
            if (idx == `IDX_LVL)
            begin
                lvl_r.hover <= pwdata_i[`HOVER_LSB +: 8];
                lvl_r.approach <= pwdata_i[`APPR_LSB +: 6];
                lvl_r.slow <= pwdata_i[`SLOW_LSB +: 2];
            end
            if (idx == `IDX_SEQ)
            begin
                last_stage_r <= pwdata_i[`LAST_LSB +: 3];
                pos_sens_r <= pwdata_i[`POS_LSB +: 4];
                neg_sens_r <= pwdata_i[`NEG_LSB +: 4];
            end
        end
    end

    // Sequence skip counter: whole sequences are dropped from the fast FIFO and flags
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            seq_cnt_r <= 4'h0;
        else if (acc && st == last_stage_r)
            seq_cnt_r <= (seq_cnt_r >= skip_r) ? 4'h0
                         : seq_cnt_r + 4'h1;
    end

    // Fast FIFO and proximity flags per stage
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < NUM_STAGES; i++)
                for (int j = 0; j < `FAST_DEPTH; j++)
                    ff_mem[i][j] <= 16'h0000;
            appr_r <= '0;
            hover_r <= '0;
        end
        else if (acc && pass)
        begin
            for (int j = `FAST_DEPTH - 1; j > 0; j--)
                ff_mem[st][j] <= ff_mem[st][j-1];
            ff_mem[st][0] <= d;
            appr_r[st] <= res.approach;
            hover_r[st] <= res.hover;
        end
    end

    // Slow filter, ambient and trip levels in stage memory
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < NUM_STAGES; i++)
            begin
                sf_mem[i] <= 16'h0000;
                amb_mem[i] <= 16'h0000;
                utrip_mem[i] <= 16'hffff;
                ltrip_mem[i] <= 16'h0000;
            end
        end
        else if (slow_upd)
        begin
            sf_mem[st] <= d;
            amb_mem[st] <= 16'(({1'b0, d} + {1'b0, sf_mem[st]}) >> 1);
            utrip_mem[st] <= trip(16'(({1'b0, d} + {1'b0, sf_mem[st]}) >> 1),
                                  uoff_mem[st], pos_sens_r, 1'b1);
            ltrip_mem[st] <= trip(16'(({1'b0, d} + {1'b0, sf_mem[st]}) >> 1),
                                  loff_mem[st], neg_sens_r, 1'b0);
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < NUM_STAGES; i++)
            begin
                uoff_mem[i] <= 16'h0000;
                loff_mem[i] <= 16'h0000;
            end
        end
        else if (wr_go && in_bank(idx, `IDX_OFFS))
        begin
            uoff_mem[sub] <= pwdata_i[15:0];
            loff_mem[sub] <= pwdata_i[31:16];
        end
    end

    // Sticky contact status: a new event beats a clear
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            stat_r <= '0;
        else if (clk_en_i)
        begin
            for (int i = 0; i < NUM_STAGES; i++)
                if (acc && contact && st == 3'(i))
                    stat_r[i] <= 1'b1;
                else if (wr_go && idx == `IDX_CLR && pwdata_i[i])
                    stat_r[i] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            ien_r <= '0;
        else if (wr_go && idx == `IDX_IEN)
            ien_r <= pwdata_i[NUM_STAGES-1:0];
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else if (clk_en_i)
            irq_o <= |(stat_r & ien_r);
    end

    // Checks
    logic acc_q;
    logic pass_q;
    logic slow_q;
    logic [2:0] st_q;
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            acc_q <= 1'b0;
            pass_q <= 1'b0;
            slow_q <= 1'b0;
            st_q <= 3'h0;
        end
        else
        begin
            acc_q <= acc;
            pass_q <= pass;
            slow_q <= slow_upd;
            st_q <= st;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    skip_bound_a: assert property (seq_cnt_r <= skip_r || $changed(skip_r)
        || $past(seq_cnt_r > skip_r))
        else $error("skip counter beyond skip count");
    skip_drop_a: assert property ((acc && !pass) |=>
        ff_mem[st_q][0] == $past(ff_mem[st][0]) && $stable(appr_r))
        else $error("skipped result reached fast fifo");
    zero_skip_a: assert property ((acc && st == last_stage_r
        && skip_r == 4'h0) |=> pass)
        else $error("sample skipped with zero skip count");
    fast_write_a: assert property ((acc && pass) |=>
        ff_mem[st_q][0] == $past(d))
        else $error("fast fifo missed a sample");
    appr_flag_a: assert property ((acc && pass) |=>
        appr_r[st_q] == $past(res.approach))
        else $error("approach flag wrong");
    hover_flag_a: assert property ((acc && pass) |=>
        hover_r[st_q] == $past(res.hover))
        else $error("hover flag wrong");
    amb_gate_a: assert property (amb_mem[st_q] != $past(amb_mem[st])
        |-> slow_q)
        else $error("ambient moved without slow update");
    prox_block_a: assert property ((acc && (pass
        ? res.approach || res.hover : appr_r[st] || hover_r[st]))
        |=> amb_mem[st_q] == $past(amb_mem[st]))
        else $error("ambient moved during proximity");
    trip_track_a: assert property (slow_upd |=>
        utrip_mem[st_q] == trip(amb_mem[st_q], uoff_mem[st_q],
                                pos_sens_r, 1'b1))
        else $error("upper trip not rewritten");
    irq_path_a: assert property ((acc && contact && clk_en_i
        && ien_r[st]) |-> ##2 irq_o)
        else $error("contact did not raise interrupt");

    fast_upd_c: cover property (acc && pass && res.approach);
    hover_c: cover property (acc && pass && res.hover);
    ambient_c: cover property (slow_upd);
    irq_c: cover property ($rose(irq_o));
endmodule
`default_nettype wire

// File: tb/touch_proximity_ambient_tracker_bench.sv
/*
 Self-checking bench of the proximity and ambient tracker: register
 access over APB, slow ambient tracking, trip crossings, interrupt and
 fast FIFO pacing by the skip count.
 Assumes the package and the design sources are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
`include "prox_track_map.svh"
module touch_proximity_ambient_tracker_bench
    import prox_track_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic cv = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] got;
    logic pready;
    logic pslverr;
    logic irq;
    logic err;
    conv_t cd = '0;
    int n_errors = 0;
    int n_tests = 0;
    int seed = 13502;
    logic [15:0] ff0 [8];
    logic [15:0] ff1 [8];
    logic [7:0] apf;
    logic [3:0] sks [4] = '{4'h0, 4'h1, 4'h2, 4'hf};

    always #5 clk = ~clk;

    touch_proximity_ambient_tracker #(.NUM_STAGES(8)) i_touch_proximity_ambient_tracker (
        .core_clk_i(clk),
        .rst_i(rst),
        .clk_en_i(en),
        .psel_i(psel),
        .penable_i(pen),
        .pwrite_i(pwr),
        .paddr_i(paddr),
        .pwdata_i(pwdata),
        .prdata_o(prdata),
        .pready_o(pready),
        .pslverr_o(pslverr),
        .conv_valid_i(cv),
        .conv_i(cd),
        .irq_o(irq)
    );

    task test_done;
        $display("mismatches %0d of %0d compares", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task chk_bit(input logic g, input logic e);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value at %0t: pin %b expected %b", $time, g, e);
        end
    endtask

    // One APB transfer; read data and error are taken at the pready edge
    task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        got = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (pready !== 1'b1)
        begin
            n_errors++;
            test_done();
        end
    endtask

    task conv(input logic [2:0] s, input logic [15:0] d, input logic on);
        @(posedge clk);
        en <= on;
        cv <= 1'b1;
        cd <= '{stage: s, data: d};
        @(posedge clk);
        en <= 1'b1;
        cv <= 1'b0;
    endtask

    task do_reset;
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
    endtask

    function automatic logic [15:0] absd(input logic [15:0] a, b);
        return (a > b) ? a - b : b - a;
    endfunction

    // Model of the approach flags with the skip counter counting sequences
    task run_skip(input logic [3:0] sk, input logic [5:0] apr);
        int cnt;
        logic pass;
        logic [15:0] d;
        cnt = 0;
        apf = 8'h00;
        for (int s = 0; s < 8; s++)
        begin
            ff0[s] = 16'h0;
            ff1[s] = 16'h0;
        end
        apb(1'b1, `IDX_SKIP, {28'h0, sk});
        apb(1'b1, `IDX_LVL, {16'h0, 2'b11, apr, 8'hff});
        repeat (4 * (sk + 1) + 1)
        begin
            pass = (cnt == 0);
            for (int s = 0; s < 8; s++)
            begin
                d = (s == 1) ? ff1[1] + {6'h0, apr, 4'h0}
                             : 16'($random(seed)) & 16'h03ff;
                if (s == 3)
                    conv(3'(s), ~d, 1'b0);
                conv(3'(s), d, 1'b1);
                if (pass)
                begin
                    apf[s] = absd(d, ff1[s]) > {6'h0, apr, 4'h0};
                    ff1[s] = ff0[s];
                    ff0[s] = d;
                end
            end
            cnt = (cnt == sk) ? 0 : cnt + 1;
            apb(1'b0, `IDX_PROX, 32'h0);
            chk(got, {24'h0, apf});
        end
    endtask

    initial
    begin
        logic [31:0] w;
        do_reset();
        apb(1'b0, `IDX_SKIP, 32'h0);
        chk(got, 32'h0);
        apb(1'b0, `IDX_LVL, 32'h0);
        chk(got, 32'h0);
        apb(1'b0, `IDX_SEQ, 32'h0);
        chk(got, 32'h7);
        chk_bit(err, 1'b0);
        apb(1'b0, `IDX_TRIP, 32'h0);
        chk(got, 32'h0000ffff);
        apb(1'b0, `IDX_AMB, 32'h0);
        chk(got, 32'h0);
        apb(1'b1, `IDX_STAT, 32'hff);
        apb(1'b0, `IDX_STAT, 32'h0);
        chk(got, 32'h0);
        apb(1'b1, 10'h3ff, 32'h1);
        chk_bit(err, 1'b1);
        apb(1'b0, 10'h3ff, 32'h0);
        chk(got, 32'h0);
        chk_bit(err, 1'b1);
        repeat (4)
        begin
            w = $random(seed);
            apb(1'b1, `IDX_LVL, w);
            apb(1'b0, `IDX_LVL, 32'h0);
            chk(got, {16'h0, w[15:0]});
            apb(1'b1, `IDX_OFFS + 10'h3, w);
            apb(1'b0, `IDX_OFFS + 10'h3, 32'h0);
            chk(got, w);
            apb(1'b1, `IDX_IEN, w);
            apb(1'b0, `IDX_IEN, 32'h0);
            chk(got, {24'h0, w[7:0]});
        end
        // Stage 0: upper offset 0x40, sensitivities 1 and 3, slow level 3
        apb(1'b1, `IDX_SEQ, 32'h0000_0317);
        apb(1'b0, `IDX_SEQ, 32'h0);
        chk(got, 32'h0000_0317);
        apb(1'b1, `IDX_IEN, 32'h0);
        apb(1'b1, `IDX_OFFS, 32'h0000_0040);
        apb(1'b1, `IDX_LVL, 32'h0000_ffff);
        conv(3'h0, 16'h0003, 1'b1);
        apb(1'b0, `IDX_AMB, 32'h0);
        chk(got, 32'h0);
        conv(3'h0, 16'h0004, 1'b1);
        apb(1'b0, `IDX_AMB, 32'h0);
        chk(got, 32'h2);
        apb(1'b0, `IDX_TRIP, 32'h0);
        chk(got, {16'h0002, 16'h0015});
        // Approach level zero: the flag blocks ambient tracking
        apb(1'b1, `IDX_LVL, 32'h0000_c0ff);
        conv(3'h0, 16'h000c, 1'b1);
        apb(1'b0, `IDX_AMB, 32'h0);
        chk(got, 32'h2);
        apb(1'b1, `IDX_LVL, 32'h0000_ffff);
        conv(3'h0, 16'h000c, 1'b1);
        apb(1'b0, `IDX_AMB, 32'h0);
        chk(got, 32'h8);
        apb(1'b0, `IDX_TRIP, 32'h0);
        chk(got, {16'h0008, 16'h001b});
        // Hover level zero: average off ambient sets the hover flag
        apb(1'b1, `IDX_LVL, 32'h0000_3f00);
        conv(3'h0, 16'h0010, 1'b1);
        apb(1'b0, `IDX_PROX, 32'h0);
        chk(got, 32'h0000_0100);
        apb(1'b0, `IDX_AMB, 32'h0);
        chk(got, 32'h8);
        // Upper crossing while masked, then enabled, cleared, lower crossing
        conv(3'h0, 16'h001e, 1'b1);
        repeat (2) @(posedge clk);
        chk_bit(irq, 1'b0);
        apb(1'b0, `IDX_STAT, 32'h0);
        chk(got, 32'h1);
        apb(1'b1, `IDX_IEN, 32'h1);
        repeat (2) @(posedge clk);
        chk_bit(irq, 1'b1);
        apb(1'b1, `IDX_CLR, 32'h1);
        repeat (2) @(posedge clk);
        chk_bit(irq, 1'b0);
        conv(3'h0, 16'h0005, 1'b1);
        repeat (2) @(posedge clk);
        chk_bit(irq, 1'b1);
        // Fast FIFO pacing, fresh reset for each skip count
        for (int i = 0; i < 4; i++)
        begin
            do_reset();
            run_skip(sks[i], 6'($random(seed)) & 6'h0f);
        end
        test_done();
    end
endmodule
`default_nettype wire
